/* src/pmc_defs.svh */
// Register offsets, reset values and field layouts of the performance monitor counter bank
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Printed offsets are register indexes; bus byte address is four times the index
`define PMC_IDX_PATTERN_HIGH 12'h90e
`define PMC_IDX_PATTERN_LOW 12'h90f
`define PMC_IDX_ZERO_HIGH 12'h910
`define PMC_IDX_ZERO_LOW 12'h911
`define PMC_IDX_SIG7_1 12'h912
`define PMC_IDX_SIG7_2 12'h913
`define PMC_IDX_SIG7_3 12'h914
`define PMC_IDX_TX_SLIP 12'h915
`define PMC_IDX_LINK2 12'h92b
`define PMC_IDX_LINK3 12'h92c
`define PMC_IDX_IRQ_STATUS 12'h940
`define PMC_IDX_IRQ_ENABLE 12'h941
`define PMC_IDX_IRQ_CLEAR 12'h942

`define PMC_CNT_RESET 8'h00
`define PMC_IRQ_RESET 8'h00

// Interrupt bit positions
`define PMC_IRQ_PATTERN 0
`define PMC_IRQ_TX_SLIP 1
`define PMC_IRQ_ZERO 2
`define PMC_IRQ_SIG7_1 3
`define PMC_IRQ_SIG7_2 4
`define PMC_IRQ_SIG7_3 5
`define PMC_IRQ_LINK2 6
`define PMC_IRQ_LINK3 7

// AXI response codes
`define PMC_RESP_OKAY 2'h0
`define PMC_RESP_SLVERR 2'h2

`endif

/* src/pmc_pkg.sv */
// Types shared by the performance monitor counter bank
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_WR_IDLE,
    PMC_WR_RESP
  } pmc_wr_state_t;
  typedef logic [7:0] pmc_byte_t;
endpackage : pmc_pkg

/* src/pmc_perf_monitor.sv */
// Performance monitor counter bank with clear-on-read counters behind an AXI4-Lite slave
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"

module pmc_perf_monitor
  import pmc_pkg::*;
#(
  parameter int ADDR_W = 14,
  parameter int BUCKET_LEAK = 256
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pattern_error_pulse,
  input wire logic tx_frame_repeat_pulse,
  input wire logic tx_frame_drop_pulse,
  input wire logic zero_violation_pulse,
  input wire logic [2:0] sig7_fcs_error_pulse,
  input wire logic link2_fcs_error_pulse,
  input wire logic link3_fcs_error_pulse,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  localparam int LEAK_W = $clog2(BUCKET_LEAK + 1);

  // Counter state
  logic [15:0] pattern_error_count_reg;
  logic [7:0] pattern_error_low_reg;
  logic [15:0] zero_violation_count_reg;
  logic [7:0] zero_violation_low_reg;
  logic [7:0] tx_slip_count_reg;
  logic [7:0] sig7_count_reg [3];
  logic [LEAK_W-1:0] sig7_leak_reg [3];
  logic [7:0] link2_error_reg;
  logic [7:0] link3_error_reg;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_enable_reg;

  // Bus state
  logic aw_held_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic w_held_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  pmc_wr_state_t wr_state_reg;

  // Read address decode; index is byte address divided by four
  wire [ADDR_W-3:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire rd_pat_hi = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_PATTERN_HIGH));
  wire rd_pat_lo = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_PATTERN_LOW));
  wire rd_zero_hi = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_ZERO_HIGH));
  wire rd_zero_lo = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_ZERO_LOW));
  wire rd_slip = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_TX_SLIP));
  wire rd_link2 = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_LINK2));
  wire rd_link3 = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_LINK3));
  wire rd_irq_st = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_IRQ_STATUS));
  wire rd_irq_en = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_IRQ_ENABLE));
  wire [2:0] rd_sig7;
  assign rd_sig7[0] = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_SIG7_1));
  assign rd_sig7[1] = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_SIG7_2));
  assign rd_sig7[2] = rd_take && (rd_idx == (ADDR_W-2)'(`PMC_IDX_SIG7_3));
  wire rd_hit = rd_pat_hi | rd_pat_lo | rd_zero_hi | rd_zero_lo | rd_slip | rd_link2
              | rd_link3 | rd_irq_st | rd_irq_en | (|rd_sig7);

  wire [7:0] rd_byte =
      rd_pat_hi ? pattern_error_count_reg[15:8] :
      rd_pat_lo ? pattern_error_low_reg :
      rd_zero_hi ? zero_violation_count_reg[15:8] :
      rd_zero_lo ? zero_violation_low_reg :
      rd_slip ? tx_slip_count_reg :
      rd_sig7[0] ? sig7_count_reg[0] :
      rd_sig7[1] ? sig7_count_reg[1] :
      rd_sig7[2] ? sig7_count_reg[2] :
      rd_link2 ? link2_error_reg :
      rd_link3 ? link3_error_reg :
      rd_irq_st ? irq_status_reg :
      rd_irq_en ? irq_enable_reg : 8'h00;

  // Write path: address and data may arrive in either order
  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held_reg && w_held_reg && (wr_state_reg == PMC_WR_IDLE);
  wire [ADDR_W-3:0] wr_idx = aw_addr_reg[ADDR_W-1:2];
  wire wr_en_hit = wr_idx == (ADDR_W-2)'(`PMC_IDX_IRQ_ENABLE);
  wire wr_clr_hit = wr_idx == (ADDR_W-2)'(`PMC_IDX_IRQ_CLEAR);
  // Counters are read-only, so only the two interrupt registers accept writes
  wire wr_ok = wr_en_hit | wr_clr_hit;
  wire wr_lane0 = wr_fire && w_strb_reg[0];
  wire [7:0] irq_clear = (wr_lane0 && wr_clr_hit) ? w_data_reg[7:0] : 8'h00;

  // A slip of either kind is one event
  wire tx_slip_event = tx_frame_repeat_pulse | tx_frame_drop_pulse;

  // Counter next values: a clearing read with an event leaves one
  wire [15:0] pattern_base = rd_pat_hi ? 16'h0000 : pattern_error_count_reg;
  wire [15:0] pattern_next = pattern_base + {15'h0000, pattern_error_pulse};
  wire [15:0] zero_base = rd_zero_hi ? 16'h0000 : zero_violation_count_reg;
  wire [15:0] zero_next = zero_base + {15'h0000, zero_violation_pulse};
  wire [7:0] slip_base = rd_slip ? 8'h00 : tx_slip_count_reg;
  wire [7:0] slip_next = slip_base + {7'h00, tx_slip_event};
  wire [7:0] link2_base = rd_link2 ? 8'h00 : link2_error_reg;
  wire [7:0] link2_next = link2_base + {7'h00, link2_fcs_error_pulse};
  wire [7:0] link3_base = rd_link3 ? 8'h00 : link3_error_reg;
  wire [7:0] link3_next = link3_base + {7'h00, link3_fcs_error_pulse};

  // Plain counters wrap rather than saturate, so a host that polls often sees every event
  // modulo the width; only the signalling buckets saturate, as a bucket must.

  // One status bit per event source
  wire [7:0] irq_events;
  assign irq_events[`PMC_IRQ_PATTERN] = pattern_error_pulse;
  assign irq_events[`PMC_IRQ_TX_SLIP] = tx_slip_event;
  assign irq_events[`PMC_IRQ_ZERO] = zero_violation_pulse;
  assign irq_events[`PMC_IRQ_SIG7_1] = sig7_fcs_error_pulse[0];
  assign irq_events[`PMC_IRQ_SIG7_2] = sig7_fcs_error_pulse[1];
  assign irq_events[`PMC_IRQ_SIG7_3] = sig7_fcs_error_pulse[2];
  assign irq_events[`PMC_IRQ_LINK2] = link2_fcs_error_pulse;
  assign irq_events[`PMC_IRQ_LINK3] = link3_fcs_error_pulse;

  // Interrupt next state: an event wins over a clear in the same cycle
  wire [7:0] irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
  wire [7:0] irq_enable_next = (wr_lane0 && wr_en_hit) ? w_data_reg[7:0] : irq_enable_reg;
  wire irq_next = |(irq_status_next & irq_enable_next);

  // Live counts; a clearing read is folded into the base selections above
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pattern_error_count_reg <= {2{`PMC_CNT_RESET}};
    end else begin
      pattern_error_count_reg <= pattern_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_violation_count_reg <= {2{`PMC_CNT_RESET}};
    end else begin
      zero_violation_count_reg <= zero_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_slip_count_reg <= `PMC_CNT_RESET;
    end else begin
      tx_slip_count_reg <= slip_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link2_error_reg <= `PMC_CNT_RESET;
    end else begin
      link2_error_reg <= link2_next;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      link3_error_reg <= `PMC_CNT_RESET;
    end else begin
      link3_error_reg <= link3_next;
    end
  end

  // Low byte is frozen at the high-byte read so later events cannot tear the pair.
  // Events after the high read go to the live count and show in the next pair.
  // A low read clears the latched byte, so a low read with no high read since the last low read returns zero.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pattern_error_low_reg <= `PMC_CNT_RESET;
    end else if (rd_pat_hi) begin
      pattern_error_low_reg <= pattern_error_count_reg[7:0];
    end else if (rd_pat_lo) begin
      pattern_error_low_reg <= `PMC_CNT_RESET;
    end
  end

  // Same pairing for the excessive-zero count
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      zero_violation_low_reg <= `PMC_CNT_RESET;
    end else if (rd_zero_hi) begin
      zero_violation_low_reg <= zero_violation_count_reg[7:0];
    end else if (rd_zero_lo) begin
      zero_violation_low_reg <= `PMC_CNT_RESET;
    end
  end

  // Leaky bucket: each error fills by one, a steady leak drains one every BUCKET_LEAK cycles
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sig7
      wire leak_tick = sig7_leak_reg[gi] == LEAK_W'(BUCKET_LEAK - 1);
      wire [7:0] cnt = rd_sig7[gi] ? 8'h00 : sig7_count_reg[gi];
      wire drain = leak_tick && (cnt != 8'h00) && !sig7_fcs_error_pulse[gi];
      wire fill = sig7_fcs_error_pulse[gi] && (cnt != 8'hff);
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          sig7_count_reg[gi] <= `PMC_CNT_RESET;
          sig7_leak_reg[gi] <= '0;
        end else begin
          sig7_leak_reg[gi] <= leak_tick ? '0 : sig7_leak_reg[gi] + LEAK_W'(1);
          sig7_count_reg[gi] <= cnt + {7'h00, fill} - {7'h00, drain};
        end
      end
    end
  endgenerate

  // Level interrupt straight from a flop; it is built from the next status and enable,
  // so it rises on the same edge as the status bit that causes it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status_reg <= `PMC_IRQ_RESET;
      irq_enable_reg <= `PMC_IRQ_RESET;
      irq <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_enable_reg <= irq_enable_next;
      irq <= irq_next;
    end
  end

  // Write readies drop on a take and stay low until the response is retired,
  // so only one write is ever in flight
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !aw_take && (wr_state_reg == PMC_WR_IDLE);
      s_axi_wready <= !w_held_reg && !w_take && (wr_state_reg == PMC_WR_IDLE);
    end
  end

  // Address and data are parked until both have arrived, in either order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (aw_take) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (w_take) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Response: the register effect and bvalid land on the same edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_state_reg <= PMC_WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PMC_RESP_OKAY;
    end else begin
      unique case (wr_state_reg)
        PMC_WR_IDLE: begin
          if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
            wr_state_reg <= PMC_WR_RESP;
          end
        end
        PMC_WR_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wr_state_reg <= PMC_WR_IDLE;
          end
        end
        default: wr_state_reg <= PMC_WR_IDLE;
      endcase
    end
  end

  // Read channel: one read at a time, data registered with the clearing read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `PMC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : pmc_perf_monitor

`default_nettype wire

/* test/pmc_perf_monitor_assertions.sv */
// Bus and counter-bank checks for the performance monitor
`timescale 1ns/1ps
`default_nettype none
module pmc_perf_monitor_assertions #(
  parameter int ADDR_W = 14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire rd_take = s_axi_arvalid && s_axi_arready;
  wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read take not answered next cycle");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid ##[0:1] s_axi_arready)
    else $error("read answer not retired");
  a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_unmapped_read: assert property (rd_take && s_axi_araddr == '0 |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_slip_read_ok: assert property (rd_take && s_axi_araddr == 14'h2454 |=> s_axi_rresp == 2'h0)
    else $error("slip counter read refused");
  a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write not answered two cycles after take");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  cover property (rd_take);
  cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h2);
  cover property ($rose(irq));
endmodule : pmc_perf_monitor_assertions

bind pmc_perf_monitor pmc_perf_monitor_assertions #(.ADDR_W(ADDR_W)) pmc_perf_monitor_assertions_inst (
  .clk, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .irq);
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the performance monitor counter bank
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"
module tb_top;
  logic clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [13:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [8:0] ev, hit;
  int fail_count, n_tests, i;
  // Short leak period so the bucket drains within the run
  pmc_perf_monitor #(.ADDR_W(14), .BUCKET_LEAK(16)) pmc_perf_monitor_inst (
    .clk, .rst_n, .pattern_error_pulse(ev[0]), .tx_frame_repeat_pulse(ev[1]),
    .tx_frame_drop_pulse(ev[2]), .zero_violation_pulse(ev[3]), .sig7_fcs_error_pulse(ev[6:4]),
    .link2_fcs_error_pulse(ev[7]), .link3_fcs_error_pulse(ev[8]), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task end_sim;
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim
  // Optional event pulse in hit lands on the edge that takes the read
  task rd(input logic [11:0] idx, output logic [31:0] q, output logic [1:0] rr);
    int k;
    @(posedge clk);
    s_axi_araddr <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ev <= hit;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      ev <= 9'h000;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    if (k == 50) begin
      fail_count++;
      end_sim();
    end
    q = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    hit = 9'h000;
  endtask : rd
  task wr(input logic [11:0] idx, input logic [31:0] v, output logic [1:0] rr);
    int k;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'b00};
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    if (k == 50) begin
      fail_count++;
      end_sim();
    end
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task fire(input logic [8:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      ev <= m;
    end
    @(posedge clk);
    ev <= 9'h000;
  endtask : fire
  task iq(input logic v);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, {31'h0, v});
  endtask : iq
  initial begin
    {ev, hit, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    rst_n = 1'b0;
    fail_count = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 10; i++) begin
      rd(12'(i < 8 ? `PMC_IDX_PATTERN_HIGH + i : `PMC_IDX_LINK2 + i - 8), d, r);
      chk(d, 32'h0);
      chk(r, `PMC_RESP_OKAY);
    end
    fire(9'h008, 300);
    rd(`PMC_IDX_ZERO_HIGH, d, r); chk(d, 32'h01);
    rd(`PMC_IDX_ZERO_LOW, d, r); chk(d, 32'h2c);
    rd(`PMC_IDX_ZERO_HIGH, d, r); chk(d, 32'h00);
    fire(9'h001, 258);
    rd(`PMC_IDX_PATTERN_HIGH, d, r); chk(d, 32'h01);
    fire(9'h001, 5);
    rd(`PMC_IDX_PATTERN_LOW, d, r); chk(d, 32'h02);
    rd(`PMC_IDX_PATTERN_HIGH, d, r); chk(d, 32'h00);
    rd(`PMC_IDX_PATTERN_LOW, d, r); chk(d, 32'h05);
    fire(9'h002, 2);
    fire(9'h004, 3);
    fire(9'h006, 1);
    rd(`PMC_IDX_TX_SLIP, d, r); chk(d, 32'h06);
    rd(`PMC_IDX_TX_SLIP, d, r); chk(d, 32'h00);
    fire(9'h080, 4);
    rd(`PMC_IDX_LINK2, d, r); chk(d, 32'h04);
    fire(9'h100, 257);
    rd(`PMC_IDX_LINK3, d, r); chk(d, 32'h01);
    hit = 9'h080;
    rd(`PMC_IDX_LINK2, d, r); chk(d, 32'h00);
    rd(`PMC_IDX_LINK2, d, r); chk(d, 32'h01);
    for (i = 0; i < 3; i++) begin
      fire(9'h010 << i, i + 1);
      // One leak step may fall between the last error and the read
      rd(12'(`PMC_IDX_SIG7_1 + i), d, r); chk(d + (d == 32'(i)), 32'(i + 1));
      rd(12'(`PMC_IDX_SIG7_1 + i), d, r); chk(d, 32'h0);
    end
    fire(9'h010, 3);
    repeat (100) @(posedge clk);
    rd(`PMC_IDX_SIG7_1, d, r); chk(d, 32'h0);
    rd(`PMC_IDX_IRQ_STATUS, d, r); chk(d, 32'hff);
    iq(1'b0);
    wr(`PMC_IDX_IRQ_ENABLE, 32'h80, r); chk(r, `PMC_RESP_OKAY);
    iq(1'b1);
    wr(`PMC_IDX_IRQ_CLEAR, 32'hff, r);
    iq(1'b0);
    fire(9'h080, 1);
    iq(1'b0);
    fire(9'h100, 1);
    iq(1'b1);
    rd(`PMC_IDX_IRQ_ENABLE, d, r); chk(d, 32'h80);
    rd(`PMC_IDX_IRQ_CLEAR, d, r); chk(r, `PMC_RESP_SLVERR);
    wr(`PMC_IDX_LINK2, 32'h5, r); chk(r, `PMC_RESP_SLVERR);
    rd(`PMC_IDX_LINK2, d, r); chk(d, 32'h01);
    rd(12'h000, d, r); chk(r, `PMC_RESP_SLVERR);
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
